//--- rtl/acsr_sequencer.sv
// channel sequencer and per-channel range store, top of the block
// assumes the host link framing of acsr_frame_rx; conv_req_i from core logic, one pulse per conversion
// limitation: registers are write-only, nothing reads back over the link
//
// Notes on behaviour
// - seq bits 00: manual channel from address bits
// - seq bits 11: also manual channel selection
// - seq 01: start at lowest enabled channel
// - programmed sequence ascends and repeats continuously
// - sequenced channels use their stored range
// - seq 10: run channel 0 to final
// - 8-bit write-only sequence enable register
// - enable bit 1 includes channel, 0 excludes
// - range low register: two bits channels 0-3
// - range low frame: ch0..ch3 upper then lower
// - stored range applied whenever channel selected
// - range high register: channels 4-7 likewise
// - every range resets to plus/minus 10 V
// - range code decode: 00,01,10,11 ranges
// - control bits 12..10 hold channel address
// - control bits 3,2 hold sequencer control
`timescale 1ns/10ps
module acsr_sequencer
	import acsr_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic link_clk_i,
	input wire logic link_sel_n_i,
	input wire logic link_din_i,
	input wire logic conv_req_i,
	output logic [2:0] conv_chan_o,
	output logic [1:0] conv_range_o,
	output logic conv_vld_o,
	output logic [1:0] seq_mode_o
);
	logic frame_vld;
	logic [FRAME_BITS-1:0] frame;
	logic [7:0] seq_en_ff, nxt_seq_en;
	logic [7:0] rng_lo_ff, nxt_rng_lo;
	logic [7:0] rng_hi_ff, nxt_rng_hi;
	logic [2:0] addr_ff, nxt_addr;
	logic [1:0] mode_ff, nxt_mode;
	logic [2:0] cur_ff, nxt_cur;
	logic started_ff, nxt_started;
	logic [2:0] chan_ff, nxt_chan;
	logic [1:0] range_ff, nxt_range;
	logic vld_ff, nxt_vld;
	logic [7:0] payload;
	logic [1:0] sel;
	logic [2:0] pick;
	logic wr_commit;
	logic ctl_commit;

	// one enable bit per channel; range pairs counted from the top bit
	localparam int CHAN_COUNT = 8;
	localparam int PAIR_TOP = 7;

	////////////////////////////////////////////////////////////////////////////////
	// frame receiver: link pins are synchronised in there, not here
	acsr_frame_rx acsr_frame_rx_i (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.link_clk_i(link_clk_i),
		.link_sel_n_i(link_sel_n_i),
		.link_din_i(link_din_i),
		.frame_vld_o(frame_vld),
		.frame_o(frame)
	);

	// next enabled channel above cur, or lowest when wrap/start
	function automatic logic [2:0] next_enabled(input logic [7:0] en, input logic [2:0] cur,
			input logic from_start);
		logic [2:0] res;
		logic found;
		res = CHAN_ZERO;
		found = 1'b0;
		for (int i = 0; i < CHAN_COUNT; i++) begin
			if (!found && en[i] && (from_start || 3'(i) > cur)) begin
				res = 3'(i);
				found = 1'b1;
			end
		end
		// nothing above cur: wrap to the lowest enabled channel
		if (!found) begin
			for (int i = 0; i < CHAN_COUNT; i++) begin
				if (!found && en[i]) begin
					res = 3'(i);
					found = 1'b1;
				end
			end
		end
		// empty enable register leaves channel 0 rather than stalling
		return res;
	endfunction

	// stored range of a channel, upper code bit first in each pair
	function automatic logic [1:0] range_of(input logic [7:0] lo, input logic [7:0] hi,
			input logic [2:0] ch);
		logic [7:0] r;
		logic [1:0] k;
		r = ch[2] ? hi : lo;
		k = ch[1:0];
		return {r[PAIR_TOP - 2 * k], r[PAIR_TOP - 1 - 2 * k]};
	endfunction

	// manual modes hold no position, so only these two track a run
	function automatic logic is_sequenced(input logic [1:0] m);
		return (m == ACSR_PROG) || (m == ACSR_CONSEC);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// registers written from frames
	// write-only: a register holds its value until the next write or reset
	always_comb begin
		payload = frame[POS_DATA_HI:POS_DATA_LO];
		sel = {frame[POS_SEL1], frame[POS_SEL2]};
		// the write flag gates every store; other frames only shift through
		wr_commit = frame_vld && frame[POS_WRITE];
		ctl_commit = wr_commit && (sel == SEL_CONTROL);
		nxt_seq_en = seq_en_ff;
		nxt_rng_lo = rng_lo_ff;
		nxt_rng_hi = rng_hi_ff;
		nxt_addr = addr_ff;
		nxt_mode = mode_ff;
		if (wr_commit) begin
			case (sel)
				// enables are msb first: ch0 at top, reverse into bit i = ch i
				SEL_SEQUENCE: nxt_seq_en = {<<{payload}};
				SEL_RANGE_LOW: nxt_rng_lo = payload;
				SEL_RANGE_HIGH: nxt_rng_hi = payload;
				SEL_CONTROL: begin
					nxt_addr = frame[POS_ADDR_HI:POS_ADDR_LO];
					nxt_mode = {frame[POS_SEQ_HI], frame[POS_SEQ_LO]};
				end
				default: nxt_mode = mode_ff;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// channel choice per conversion request
	// one answer per request, exactly a cycle later, unless a control write commits in the request's cycle
	always_comb begin
		nxt_cur = cur_ff;
		nxt_started = started_ff;
		nxt_chan = chan_ff;
		nxt_range = range_ff;
		nxt_vld = 1'b0;
		pick = cur_ff;
		// any control write restarts a sequence at its first channel
		// restart wins over a request in the same cycle: that request is dropped
		if (ctl_commit) begin
			nxt_started = 1'b0;
		end else if (conv_req_i) begin
			case (acsr_seq_mode_type'(mode_ff))
				ACSR_PROG: pick = next_enabled(seq_en_ff, cur_ff, !started_ff);
				ACSR_CONSEC: begin
					// fresh start or final channel reached: back to channel 0
					if (!started_ff || cur_ff >= addr_ff) begin
						pick = CHAN_ZERO;
					end else begin
						pick = cur_ff + 3'h1;
					end
				end
				ACSR_MANUAL_type_a: pick = addr_ff;
				ACSR_MANUAL_type_b: pick = addr_ff;
				default: pick = addr_ff;
			endcase
			nxt_cur = pick;
			nxt_started = is_sequenced(mode_ff);
			nxt_chan = pick;
			nxt_range = range_of(rng_lo_ff, rng_hi_ff, pick);
			nxt_vld = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// stored registers; ranges reset to the widest bipolar range
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			seq_en_ff <= SEQ_REG_RESET;
			rng_lo_ff <= RANGE_REG_RESET;
			rng_hi_ff <= RANGE_REG_RESET;
			addr_ff <= CHAN_ZERO;
			mode_ff <= ACSR_MANUAL_type_a;
		end else begin
			seq_en_ff <= nxt_seq_en;
			rng_lo_ff <= nxt_rng_lo;
			rng_hi_ff <= nxt_rng_hi;
			addr_ff <= nxt_addr;
			mode_ff <= nxt_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequence position and conversion outputs
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			cur_ff <= CHAN_ZERO;
			started_ff <= 1'b0;
			chan_ff <= CHAN_ZERO;
			range_ff <= RANGE_PM10;
			vld_ff <= 1'b0;
		end else begin
			cur_ff <= nxt_cur;
			started_ff <= nxt_started;
			chan_ff <= nxt_chan;
			range_ff <= nxt_range;
			vld_ff <= nxt_vld;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// every output comes straight from a flip-flop
	assign conv_chan_o = chan_ff;
	assign conv_range_o = range_ff;
	assign conv_vld_o = vld_ff;
	assign seq_mode_o = mode_ff;
endmodule

//--- inc/acsr_pkg.sv
// constants, field layouts and types for the channel sequencer and range block
// assumes a 16-clock serial frame, msb first, framed by an active-low select
package acsr_pkg;
	localparam int FRAME_BITS = 16;
	localparam logic [3:0] FRAME_LAST = 4'hf;
	// frame bit n (1..16) sits at shift index n-1
	localparam int POS_WRITE = 15;
	localparam int POS_SEL1 = 14;
	localparam int POS_SEL2 = 13;
	localparam int POS_DATA_HI = 12;
	localparam int POS_DATA_LO = 5;
	localparam int POS_ADDR_HI = 11;
	localparam int POS_ADDR_LO = 9;
	localparam int POS_SEQ_HI = 2;
	localparam int POS_SEQ_LO = 1;
	// register select codes, sel1 then sel2
	localparam logic [1:0] SEL_CONTROL = 2'h0;
	localparam logic [1:0] SEL_RANGE_LOW = 2'h1;
	localparam logic [1:0] SEL_RANGE_HIGH = 2'h2;
	localparam logic [1:0] SEL_SEQUENCE = 2'h3;
	// range codes, upper bit then lower bit
	localparam logic [1:0] RANGE_PM10 = 2'h0;
	localparam logic [1:0] RANGE_PM5 = 2'h1;
	localparam logic [1:0] RANGE_PM2P5 = 2'h2;
	localparam logic [1:0] RANGE_UNI10 = 2'h3;
	localparam logic [7:0] RANGE_REG_RESET = 8'h00;
	localparam logic [7:0] SEQ_REG_RESET = 8'h00;
	localparam logic [2:0] CHAN_ZERO = 3'h0;
	localparam logic [2:0] CHAN_LAST = 3'h7;
	typedef enum logic [1:0] {
		ACSR_MANUAL_type_a,
		ACSR_PROG,
		ACSR_CONSEC,
		ACSR_MANUAL_type_b
	} acsr_seq_mode_type;
endpackage

//--- rtl/acsr_frame_rx.sv
// serial frame receiver: samples link pins and assembles 16-bit frames
// assumes link pins are asynchronous to core_clk_i; data taken on falling link clock
`timescale 1ns/10ps
module acsr_frame_rx
	import acsr_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic link_clk_i,
	input wire logic link_sel_n_i,
	input wire logic link_din_i,
	output logic frame_vld_o,
	output logic [FRAME_BITS-1:0] frame_o
);
	logic [2:0] clk_sync_ff, nxt_clk_sync;
	logic [1:0] sel_sync_ff, nxt_sel_sync;
	logic [1:0] din_sync_ff, nxt_din_sync;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [FRAME_BITS-1:0] shift_ff, nxt_shift;
	logic vld_ff, nxt_vld;
	logic [FRAME_BITS-1:0] out_ff, nxt_out;
	logic fall;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_clk_sync = {clk_sync_ff[1:0], link_clk_i};
		nxt_sel_sync = {sel_sync_ff[0], link_sel_n_i};
		nxt_din_sync = {din_sync_ff[0], link_din_i};
		// edge seen only between stages two and three
		fall = clk_sync_ff[2] & ~clk_sync_ff[1];
		nxt_cnt = cnt_ff;
		nxt_shift = shift_ff;
		nxt_vld = 1'b0;
		nxt_out = out_ff;
		if (sel_sync_ff[1]) begin
			// deselect aborts a partial frame, nothing is written
			nxt_cnt = 4'h0;
		end else if (fall) begin
			nxt_shift = {shift_ff[FRAME_BITS-2:0], din_sync_ff[1]};
			nxt_cnt = cnt_ff + 4'h1;
			if (cnt_ff == FRAME_LAST) begin
				nxt_vld = 1'b1;
				nxt_out = {shift_ff[FRAME_BITS-2:0], din_sync_ff[1]};
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			clk_sync_ff <= 3'h7; // idle level of the link clock, no false edge after reset
			sel_sync_ff <= 2'h3;
			din_sync_ff <= 2'h0;
			cnt_ff <= 4'h0;
			shift_ff <= '0;
			vld_ff <= 1'b0;
			out_ff <= '0;
		end else begin
			clk_sync_ff <= nxt_clk_sync;
			sel_sync_ff <= nxt_sel_sync;
			din_sync_ff <= nxt_din_sync;
			cnt_ff <= nxt_cnt;
			shift_ff <= nxt_shift;
			vld_ff <= nxt_vld;
			out_ff <= nxt_out;
		end
	end

	assign frame_vld_o = vld_ff;
	assign frame_o = out_ff;
endmodule

//--- test/acsr_properties.sv
// checker for the sequencer top, sees only its ports
// assumes one core clock domain, synchronous reset
`timescale 1ns/10ps
module acsr_properties (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic link_sel_n_i,
	input wire logic conv_req_i,
	input wire logic [2:0] conv_chan_o,
	input wire logic [1:0] conv_range_o,
	input wire logic conv_vld_o,
	input wire logic [1:0] seq_mode_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	////////////////////////////////////////
	vld_cause_a: assert property (conv_vld_o |-> $past(conv_req_i))
		else $error("valid without request");
	// quiet link for 8 cycles: no commit can drop the request
	req_answer_a: assert property (conv_req_i && link_sel_n_i
		&& $past(link_sel_n_i, 8) |=> conv_vld_o)
		else $error("request not answered");
	out_hold_a: assert property (!conv_vld_o |-> $stable(conv_chan_o) && $stable(conv_range_o))
		else $error("outputs moved without valid");
	manual_same_a: assert property ((seq_mode_o == 2'h0 || seq_mode_o == 2'h3)
		&& conv_vld_o && $past(conv_vld_o) |-> $stable(conv_chan_o))
		else $error("manual channel moved");
	consec_step_a: assert property (seq_mode_o == 2'h2 && conv_vld_o
		&& $past(conv_vld_o) |-> conv_chan_o == $past(conv_chan_o) + 3'h1
		|| conv_chan_o == 3'h0)
		else $error("consecutive step wrong");
	// quiet link: a range write between two answers may legally move the range
	chan_range_a: assert property (conv_vld_o && $past(conv_vld_o)
		&& $stable(conv_chan_o) && link_sel_n_i && $past(link_sel_n_i, 8)
		|-> $stable(conv_range_o))
		else $error("range differs for same channel");
	mode_frame_a: assert property ($changed(seq_mode_o) |-> !$past(link_sel_n_i, 10))
		else $error("mode changed without frame");
	reset_zero_a: assert property (disable iff (1'b0) sys_rst_i |=>
		conv_chan_o == 3'h0 && conv_range_o == 2'h0 && !conv_vld_o && seq_mode_o == 2'h0)
		else $error("reset values wrong");
	cover property (seq_mode_o == 2'h0 && conv_vld_o && $past(conv_vld_o));
	cover property (seq_mode_o == 2'h1 && conv_vld_o);
	cover property (seq_mode_o == 2'h2 && conv_vld_o);
	cover property (seq_mode_o == 2'h3 && conv_vld_o);
endmodule
bind acsr_sequencer acsr_properties acsr_properties_i (.core_clk_i(core_clk_i),
	.sys_rst_i(sys_rst_i), .link_sel_n_i(link_sel_n_i), .conv_req_i(conv_req_i),
	.conv_chan_o(conv_chan_o), .conv_range_o(conv_range_o), .conv_vld_o(conv_vld_o),
	.seq_mode_o(seq_mode_o));

//--- test/acsr_host_model.sv
// host side of the serial link: sends 16-bit frames msb first
// assumes the device samples data on the falling link clock
`timescale 1ns/10ps
module acsr_host_model (
	output logic link_clk_o,
	output logic link_sel_n_o,
	output logic link_din_o
);
	// clock stands high between frames
	initial begin
		link_clk_o = 1'b1;
		link_sel_n_o = 1'b1;
		link_din_o = 1'b0;
	end
	task automatic send(input logic [15:0] f);
		link_sel_n_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			link_din_o = f[i];
			#16 link_clk_o = 1'b0;
			#16 link_clk_o = 1'b1;
		end
		link_din_o = ~f[0]; // released line shows no stale bit
		#16 link_sel_n_o = 1'b1;
	endtask
endmodule

//--- test/tb.sv
// self-checking bench for the channel sequencer and range store
// assumes the host model drives the link, bench drives conversion requests
`timescale 1ns/10ps
module tb;
	import acsr_pkg::*;
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic conv_req_i = 1'b0;
	logic link_clk, link_sel_n, link_din, conv_vld_o;
	logic [2:0] conv_chan_o;
	logic [1:0] conv_range_o, seq_mode_o;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;
	logic [1:0] rg [8] = '{default: 2'h0};
	logic [2:0] runs [10] = '{3'h1, 3'h4, 3'h6, 3'h1, 3'h4, 3'h0, 3'h1, 3'h2, 3'h0, 3'h1};
	always #2 core_clk_i = ~core_clk_i;
	acsr_host_model acsr_host_model_i (.link_clk_o(link_clk), .link_sel_n_o(link_sel_n),
		.link_din_o(link_din));
	acsr_sequencer acsr_sequencer_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.link_clk_i(link_clk), .link_sel_n_i(link_sel_n), .link_din_i(link_din),
		.conv_req_i(conv_req_i), .conv_chan_o(conv_chan_o), .conv_range_o(conv_range_o),
		.conv_vld_o(conv_vld_o), .seq_mode_o(seq_mode_o));
	////////////////////////////////////////
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [2:0] e, input logic [2:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	// gap after frame keeps requests clear of the commit
	task automatic wr(input logic [15:0] f);
		acsr_host_model_i.send(f);
		repeat (12) @(negedge core_clk_i);
	endtask
	task automatic ask(input logic [2:0] ch);
		conv_req_i = 1'b1;
		@(negedge core_clk_i);
		chk("valid", 3'h1, {2'h0, conv_vld_o});
		chk("channel", ch, conv_chan_o);
		chk("range", {1'b0, rg[ch]}, {1'b0, conv_range_o});
	endtask
	function automatic logic [15:0] ctl(input logic [2:0] a, input logic [1:0] s);
		return {3'h4, 1'b0, a, 6'h0, s, 1'b0};
	endfunction
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			print_verdict();
		end
	end
	////////////////////////////////////////
	initial begin
		repeat (3) @(negedge core_clk_i);
		sys_rst_i = 1'b0;
		@(negedge core_clk_i);
		ask(3'h0);
		conv_req_i = 1'b0;
		wr(ctl(3'h7, 2'h2));
		for (int i = 0; i < 9; i++) ask(3'(i));
		conv_req_i = 1'b0;
		wr(ctl(3'h0, 2'h0));
		wr({1'b1, SEL_RANGE_LOW, 8'he4, 5'h0});
		wr({1'b1, SEL_RANGE_HIGH, 8'h6c, 5'h0});
		wr({1'b0, SEL_RANGE_LOW, 8'hff, 5'h0});
		rg = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
		for (int a = 0; a < 8; a++) begin
			wr(ctl(3'(a), a[0] ? 2'h3 : 2'h0));
			ask(3'(a));
			ask(3'(a));
			conv_req_i = 1'b0;
			chk("mode", a[0] ? 3'h3 : 3'h0, {1'b0, seq_mode_o});
			@(negedge core_clk_i);
			chk("valid", 3'h0, {2'h0, conv_vld_o});
		end
		wr({1'b1, SEL_SEQUENCE, 8'h4a, 5'h0});
		wr(ctl(3'h0, 2'h1));
		for (int i = 0; i < 5; i++) ask(runs[i]);
		conv_req_i = 1'b0;
		wr(ctl(3'h2, 2'h2));
		for (int i = 5; i < 10; i++) ask(runs[i]);
		conv_req_i = 1'b0;
		print_verdict();
	end
endmodule
